// ---- rtl/csfbdm_regs.svh ----
// constants of the condition flag register and banked data memory map
// How it works
// RULE1: flag register accepts any instruction as destination
// RULE2: flag-updating ops block writes to arithmetic flags
// RULE3: timeout and power-down flags ignore writes
// RULE4: clear on flag register gives 000u u1uu
// RULE5: upper three bits read zero, ignore writes
// RULE6: timeout flag set by power-up, clear-watchdog, sleep
// RULE7: power-down flag set power-up/clear-watchdog, cleared sleep
// RULE8: zero flag follows result equal zero
// RULE9: digit carry from bit 3 on add/sub
// RULE10: carry from bit 7 on add/sub
// RULE11: subtract adds two's complement, carry means no borrow
// RULE12: rotates load carry with shifted-out bit
// RULE13: power-on sets cause flags, clears arithmetic flags
// RULE14: software should alter flags with non-flag instructions
// RULE15: peripheral registers at bank offsets 0x0C-0x1F
// RULE16: up to 80 general RAM bytes per bank
// RULE17: 16 common RAM bytes shared by all banks
// RULE18: general RAM also linear via indirect pointer
// RULE19: 32 banks of 128 bytes, bank select register
// RULE20: 12-bit address, bank in upper five bits
// RULE21: unimplemented locations read zero
// RULE22: core registers at first 12 bank addresses
`ifndef CSFBDM_REGS_SVH
`define CSFBDM_REGS_SVH
`define CSFBDM_FLAGS_OFFSET   7'h03
`define CSFBDM_BANKSEL_OFFSET 7'h08
`define CSFBDM_CORE_LAST      7'h0B
`define CSFBDM_PERIPH_FIRST   7'h0C
`define CSFBDM_PERIPH_LAST    7'h1F
`define CSFBDM_RAM_FIRST      7'h20
`define CSFBDM_RAM_LAST       7'h6F
`define CSFBDM_COMMON_FIRST   7'h70
`define CSFBDM_RAM_BYTES      80
`define CSFBDM_LINEAR_BASE    16'h2000
`define CSFBDM_BIT_TIMEOUT    4
`define CSFBDM_BIT_PWRDN      3
`define CSFBDM_BIT_Z          2
`define CSFBDM_BIT_DIGIT      1
`define CSFBDM_BIT_C          0
`define CSFBDM_FLAGS_POR      8'h18
`define CSFBDM_FLAGS_MASK     8'h1F
`endif

// ---- rtl/csfbdm_pkg.sv ----
// types for the condition flag register and banked data memory
`default_nettype none
package csfbdm_pkg;
  typedef enum logic [3:0] {
    CSFBDM_OP_NONE,
    CSFBDM_OP_MOVE,
    CSFBDM_OP_LOGIC,
    CSFBDM_OP_ADD,
    CSFBDM_OP_SUB,
    CSFBDM_OP_CLEAR,
    CSFBDM_OP_ROT_LEFT,
    CSFBDM_OP_ROT_RIGHT
  } csfbdm_op_t;
  typedef enum logic [1:0] {
    CSFBDM_EV_NONE,
    CSFBDM_EV_WATCHDOG_CLEAR,
    CSFBDM_EV_SLEEP,
    CSFBDM_EV_WATCHDOG_TIMEOUT
  } csfbdm_event_t;
  typedef struct packed {
    logic       [6:0] offset;
    logic       [7:0] wdata;
    logic             write;
    logic             is_flags;
  } csfbdm_access_t;
  typedef struct packed {
    logic [7:0] result;
    logic       z;
    logic       digit;
    logic       c;
    logic       affects_z;
    logic       affects_cdc;
  } csfbdm_alu_t;
endpackage
`default_nettype wire

// ---- rtl/csfbdm_alu.sv ----
// alu that produces a result and the three arithmetic flags
`include "csfbdm_regs.svh"
`default_nettype none
module csfbdm_alu
(
  // operands
  input  wire csfbdm_pkg::csfbdm_op_t  op,
  input  wire logic [7:0]              w_value,
  input  wire logic [7:0]              f_value,
  input  wire logic                    carry_in,
  // outcome
  output csfbdm_pkg::csfbdm_alu_t      outcome
);
  import csfbdm_pkg::*;
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] addend;
  // subtraction feeds the inverted operand plus one, so carry set means no borrow
  always_comb
  begin
    addend  = (op == CSFBDM_OP_SUB) ? ~w_value : w_value; // RULE11
    sum     = {1'b0, f_value} + {1'b0, addend} + {8'h00, (op == CSFBDM_OP_SUB)};
    low_sum = {1'b0, f_value[3:0]} + {1'b0, addend[3:0]} + {4'h0, (op == CSFBDM_OP_SUB)};
    outcome = '0;
    outcome.c = carry_in;
    case (op)
      CSFBDM_OP_ADD, CSFBDM_OP_SUB:
      begin
        outcome.result      = sum[7:0];
        outcome.c           = sum[8];      // RULE10
        outcome.digit       = low_sum[4];  // RULE9
        outcome.affects_z   = 1'b1;
        outcome.affects_cdc = 1'b1;
      end
      CSFBDM_OP_LOGIC:
      begin
        outcome.result    = f_value & w_value;
        outcome.affects_z = 1'b1;
      end
      CSFBDM_OP_CLEAR:
      begin
        outcome.result    = 8'h00;
        outcome.affects_z = 1'b1;
      end
      CSFBDM_OP_ROT_LEFT:
      begin
        outcome.result = {f_value[6:0], carry_in};
        outcome.c      = f_value[7]; // RULE12
      end
      CSFBDM_OP_ROT_RIGHT:
      begin
        outcome.result = {carry_in, f_value[7:1]};
        outcome.c      = f_value[0]; // RULE12
      end
      CSFBDM_OP_MOVE:
      begin
        outcome.result = w_value;
      end
      default:
      begin
        outcome.result = f_value;
      end
    endcase
    outcome.z = (outcome.result == 8'h00); // RULE8
  end
endmodule
`default_nettype wire

// ---- rtl/csfbdm_decode.sv ----
// classifies a 12-bit data address into its memory region
`include "csfbdm_regs.svh"
`default_nettype none
module csfbdm_decode
(
  // address
  input  wire logic [11:0] addr,
  // region flags
  output logic             is_core,
  output logic             is_periph,
  output logic             is_ram,
  output logic             is_common,
  output logic [11:0]      ram_index,
  output logic [3:0]       common_index
);
  // bank in upper five bits, location in lower seven
  always_comb
  begin
    is_core      = addr[6:0] <= `CSFBDM_CORE_LAST; // RULE22 RULE20
    is_periph    = (addr[6:0] >= `CSFBDM_PERIPH_FIRST) && (addr[6:0] <= `CSFBDM_PERIPH_LAST); // RULE15
    is_ram       = (addr[6:0] >= `CSFBDM_RAM_FIRST) && (addr[6:0] <= `CSFBDM_RAM_LAST); // RULE16
    is_common    = addr[6:0] >= `CSFBDM_COMMON_FIRST; // RULE17
    // widen the bank before the product, as bank 31 times 80 needs all twelve bits
    ram_index    = ({7'h00, addr[11:7]} * 12'(`CSFBDM_RAM_BYTES)) + {5'h00, 7'(addr[6:0] - `CSFBDM_RAM_FIRST)};
    common_index = addr[3:0];
  end
endmodule
`default_nettype wire

// ---- rtl/csfbdm_core.sv ----
// condition flag register and banked data memory of the cpu core
`include "csfbdm_regs.svh"
`default_nettype none
module csfbdm_core
#(
  parameter int RAM_BANKS = 32
)
(
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      resetn,
  // other reset cause: timeout and power-down set per cause
  input  wire logic                      other_reset,
  input  wire logic                      other_reset_to,
  input  wire logic                      other_reset_pd,
  // instruction stream
  input  wire logic                      instr_valid,
  input  wire csfbdm_pkg::csfbdm_op_t    instr_op,
  input  wire logic [6:0]                instr_offset,
  input  wire logic                      instr_dest_f,
  input  wire logic [7:0]                w_value,
  input  wire csfbdm_pkg::csfbdm_event_t core_event,
  // indirect access
  input  wire logic [15:0]               indirect_pointer,
  input  wire logic                      indirect_write,
  input  wire logic                      indirect_read,
  input  wire logic [7:0]                indirect_wdata,
  // results
  output logic [7:0]                     cpu_condition_flags,
  output logic [4:0]                     bank_select_reg,
  output logic [7:0]                     read_data,
  output logic [7:0]                     indirect_rdata,
  output logic [7:0]                     alu_result
);
  import csfbdm_pkg::*;

  localparam int RAM_WORDS = RAM_BANKS * `CSFBDM_RAM_BYTES;

  logic [7:0]  ram_mem [RAM_WORDS];
  logic [7:0]  common_mem [16];
  logic [7:0]  next_cpu_condition_flags;
  logic [4:0]  next_bank_select_reg;
  logic [7:0]  next_read_data;
  logic [7:0]  next_indirect_rdata;
  logic [7:0]  next_alu_result;
  logic [11:0] dir_addr;
  logic [11:0] ind_addr;
  logic        d_core, d_periph, d_ram, d_common;
  logic        i_core, i_periph, i_ram, i_common;
  logic        flag_op;
  logic [11:0] d_gidx, i_gidx;
  logic [3:0]  d_cidx, i_cidx;
  logic [7:0]  f_value;
  logic        linear;
  logic [11:0] lin_index;
  csfbdm_alu_t outcome;

  // bank select register picks the bank for direct addressing
  assign dir_addr  = {bank_select_reg, instr_offset}; // RULE19
  assign ind_addr  = indirect_pointer[11:0];
  assign linear    = indirect_pointer[15:13] == `CSFBDM_LINEAR_BASE >> 13;
  assign lin_index = indirect_pointer[11:0];

  csfbdm_decode u_dir_decode
  (
    .addr         (dir_addr),
    .is_core      (d_core),
    .is_periph    (d_periph),
    .is_ram       (d_ram),
    .is_common    (d_common),
    .ram_index    (d_gidx),
    .common_index (d_cidx)
  );

  csfbdm_decode u_ind_decode
  (
    .addr         (ind_addr),
    .is_core      (i_core),
    .is_periph    (i_periph),
    .is_ram       (i_ram),
    .is_common    (i_common),
    .ram_index    (i_gidx),
    .common_index (i_cidx)
  );

  // operand fetch for the direct access; unimplemented space reads zero
  always_comb
  begin
    f_value = 8'h00; // RULE21
    if (instr_offset == `CSFBDM_FLAGS_OFFSET)
      f_value = cpu_condition_flags;
    else if (instr_offset == `CSFBDM_BANKSEL_OFFSET)
      f_value = {3'b000, bank_select_reg};
    else if (d_ram && (int'(d_gidx) < RAM_WORDS))
      f_value = ram_mem[d_gidx];
    else if (d_common)
      f_value = common_mem[d_cidx]; // RULE17
  end

  csfbdm_alu u_alu
  (
    .op       (instr_op),
    .w_value  (w_value),
    .f_value  (f_value),
    .carry_in (cpu_condition_flags[`CSFBDM_BIT_C]),
    .outcome  (outcome)
  );

  // any op that touches a flag blocks the written value for all three arithmetic flags,
  // so a clear keeps digit carry and carry as they were
  assign flag_op = outcome.affects_z || outcome.affects_cdc ||
                   instr_op == CSFBDM_OP_ROT_LEFT || instr_op == CSFBDM_OP_ROT_RIGHT; // RULE2

  // flag register next value: write, then alu flags win, then protected bits
  always_comb
  begin
    next_cpu_condition_flags = cpu_condition_flags;
    next_bank_select_reg     = bank_select_reg;
    next_alu_result          = alu_result;
    next_read_data           = f_value;
    if (instr_valid && instr_op != CSFBDM_OP_NONE)
    begin
      next_alu_result = outcome.result;
      if (instr_dest_f && instr_offset == `CSFBDM_FLAGS_OFFSET && !flag_op)
        next_cpu_condition_flags[2:0] = outcome.result[2:0]; // RULE1 RULE3 RULE5
      if (instr_dest_f && instr_offset == `CSFBDM_BANKSEL_OFFSET)
        next_bank_select_reg = outcome.result[4:0];
      if (outcome.affects_z)
        next_cpu_condition_flags[`CSFBDM_BIT_Z] = outcome.z; // RULE2 RULE4
      if (outcome.affects_cdc)
      begin
        next_cpu_condition_flags[`CSFBDM_BIT_DIGIT] = outcome.digit; // RULE2
        next_cpu_condition_flags[`CSFBDM_BIT_C]     = outcome.c;
      end
      if (instr_op == CSFBDM_OP_ROT_LEFT || instr_op == CSFBDM_OP_ROT_RIGHT)
        next_cpu_condition_flags[`CSFBDM_BIT_C] = outcome.c; // RULE12
    end
    case (core_event)
      CSFBDM_EV_WATCHDOG_CLEAR:
      begin
        next_cpu_condition_flags[`CSFBDM_BIT_TIMEOUT] = 1'b1; // RULE6
        next_cpu_condition_flags[`CSFBDM_BIT_PWRDN]   = 1'b1; // RULE7
      end
      CSFBDM_EV_SLEEP:
      begin
        next_cpu_condition_flags[`CSFBDM_BIT_TIMEOUT] = 1'b1; // RULE6
        next_cpu_condition_flags[`CSFBDM_BIT_PWRDN]   = 1'b0; // RULE7
      end
      CSFBDM_EV_WATCHDOG_TIMEOUT:
        next_cpu_condition_flags[`CSFBDM_BIT_TIMEOUT] = 1'b0; // RULE6
      default:
        next_cpu_condition_flags = next_cpu_condition_flags;
    endcase
    if (other_reset)
    begin
      next_cpu_condition_flags[`CSFBDM_BIT_TIMEOUT] = other_reset_to; // RULE13
      next_cpu_condition_flags[`CSFBDM_BIT_PWRDN]   = other_reset_pd;
    end
    next_cpu_condition_flags = next_cpu_condition_flags & `CSFBDM_FLAGS_MASK; // RULE5
  end

  // indirect read data; linear space spans the per-bank ram contiguously
  always_comb
  begin
    next_indirect_rdata = indirect_rdata;
    if (indirect_read)
    begin
      next_indirect_rdata = 8'h00; // RULE21
      if (linear && int'(lin_index) < RAM_WORDS)
        next_indirect_rdata = ram_mem[lin_index]; // RULE18
      else if (!linear && indirect_pointer[15:12] == 4'h0)
      begin
        if (i_ram && int'(i_gidx) < RAM_WORDS)
          next_indirect_rdata = ram_mem[i_gidx];
        else if (i_common)
          next_indirect_rdata = common_mem[i_cidx];
        else if (i_core && ind_addr[6:0] == `CSFBDM_FLAGS_OFFSET)
          next_indirect_rdata = cpu_condition_flags;
      end
    end
  end

  // register state; power-on values on reset
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      cpu_condition_flags <= `CSFBDM_FLAGS_POR; // RULE13
      bank_select_reg     <= 5'h00;
      read_data           <= 8'h00;
      indirect_rdata      <= 8'h00;
      alu_result          <= 8'h00;
    end
    else
    begin
      cpu_condition_flags <= next_cpu_condition_flags;
      bank_select_reg     <= next_bank_select_reg;
      read_data           <= next_read_data;
      indirect_rdata      <= next_indirect_rdata;
      alu_result          <= next_alu_result;
    end
  end

  // ram writes; memories carry no reset, as real sram does not
  always_ff @(posedge mclk)
  begin
    if (resetn && instr_valid && instr_dest_f && instr_op != CSFBDM_OP_NONE)
    begin
      if (d_ram && int'(d_gidx) < RAM_WORDS)
        ram_mem[d_gidx] <= outcome.result;
      else if (d_common)
        common_mem[d_cidx] <= outcome.result;
    end
    else if (resetn && indirect_write)
    begin
      if (linear && int'(lin_index) < RAM_WORDS)
        ram_mem[lin_index] <= indirect_wdata;
      else if (!linear && indirect_pointer[15:12] == 4'h0 && i_ram && int'(i_gidx) < RAM_WORDS)
        ram_mem[i_gidx] <= indirect_wdata;
      else if (!linear && indirect_pointer[15:12] == 4'h0 && i_common)
        common_mem[i_cidx] <= indirect_wdata;
    end
  end
endmodule
`default_nettype wire

// ---- test/csfbdm_core_sva.sv ----
// port assertions for the flag register and banked data memory core
`default_nettype none
module csfbdm_core_sva
  import csfbdm_pkg::*;
#(
  parameter int RAM_BANKS = 32
)
(
  // clock and reset
  input wire logic          mclk,
  input wire logic          resetn,
  // requests
  input wire logic          other_reset,
  input wire logic          other_reset_to,
  input wire logic          other_reset_pd,
  input wire logic          instr_valid,
  input wire csfbdm_op_t    instr_op,
  input wire logic [6:0]    instr_offset,
  input wire logic          instr_dest_f,
  input wire logic [7:0]    w_value,
  input wire csfbdm_event_t core_event,
  // results
  input wire logic [7:0]    cpu_condition_flags,
  input wire logic [4:0]    bank_select_reg,
  input wire logic [7:0]    read_data,
  input wire logic [7:0]    alu_result
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // a flag register write with no event or other reset competing for the cause flags
  sequence s_flag_dest;
    instr_valid && instr_offset == 7'h03 && instr_dest_f && core_event == CSFBDM_EV_NONE && !other_reset;
  endsequence
  sequence s_op(csfbdm_op_t o);
    instr_valid && instr_op == o && !other_reset;
  endsequence
  a_upper_zero: assert property (cpu_condition_flags[7:5] == 3'h0) else $error("upper flag bits set");
  a_por_value: assert property ($rose(resetn) |-> cpu_condition_flags == 8'h18 && bank_select_reg == 5'h00)
    else $error("wrong reset value");
  a_cause_protect: assert property (s_flag_dest |=>
    cpu_condition_flags[4:3] == $past(cpu_condition_flags[4:3])) else $error("cause flags written");
  a_clear_pattern: assert property (s_flag_dest ##0 instr_op == CSFBDM_OP_CLEAR |=>
    cpu_condition_flags == (($past(cpu_condition_flags) & 8'h1B) | 8'h04)) else $error("clear pattern wrong");
  a_sleep_flags: assert property (core_event == CSFBDM_EV_SLEEP && !other_reset |=>
    cpu_condition_flags[4:3] == 2'b10) else $error("sleep flags wrong");
  a_watchdog_clear: assert property (core_event == CSFBDM_EV_WATCHDOG_CLEAR && !other_reset |=>
    cpu_condition_flags[4:3] == 2'b11) else $error("watchdog clear flags wrong");
  a_watchdog_timeout: assert property (core_event == CSFBDM_EV_WATCHDOG_TIMEOUT && !other_reset |=>
    !cpu_condition_flags[4]) else $error("timeout flag wrong");
  a_other_reset: assert property (other_reset && !instr_valid |=>
    cpu_condition_flags[4:3] == {$past(other_reset_to), $past(other_reset_pd)} &&
    (cpu_condition_flags & 8'h07) == ($past(cpu_condition_flags) & 8'h07)) else $error("other reset flags wrong");
  a_add_zero: assert property (s_op(CSFBDM_OP_ADD) |=> cpu_condition_flags[2] == (alu_result == 8'h00))
    else $error("zero flag wrong");
  a_add_carry: assert property (s_op(CSFBDM_OP_ADD) |=>
    cpu_condition_flags[0] == (({1'b0, read_data} + {1'b0, $past(w_value)}) > 9'h0FF)) else $error("carry wrong");
  a_sub_borrow: assert property (s_op(CSFBDM_OP_SUB) |=> cpu_condition_flags[0] == (read_data >= $past(w_value)))
    else $error("borrow wrong");
  a_rot_carry: assert property (s_op(CSFBDM_OP_ROT_LEFT) |=> cpu_condition_flags[0] == read_data[7])
    else $error("rotate carry wrong");
endmodule
bind csfbdm_core csfbdm_core_sva #(.RAM_BANKS(RAM_BANKS)) u_sva (.mclk, .resetn, .other_reset, .other_reset_to,
  .other_reset_pd, .instr_valid, .instr_op, .instr_offset, .instr_dest_f, .w_value, .core_event,
  .cpu_condition_flags, .bank_select_reg, .read_data, .alu_result);
`default_nettype wire

// ---- test/cpu_status_flags_and_banked_data_memory_bench.sv ----
// self-checking bench for the flag register and banked data memory core
`default_nettype none
module cpu_status_flags_and_banked_data_memory_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import csfbdm_pkg::*;
  typedef struct {int due; int sel; logic [7:0] val;} csfbdm_note_t;
  logic          mclk = 1'b0, resetn = 1'b0, instr_valid = 1'b0, instr_dest_f = 1'b0;
  logic          other_reset = 1'b0, other_reset_to = 1'b0, other_reset_pd = 1'b0;
  logic          indirect_write = 1'b0, indirect_read = 1'b0;
  csfbdm_op_t    instr_op = CSFBDM_OP_NONE;
  csfbdm_event_t core_event = CSFBDM_EV_NONE;
  logic [6:0]    instr_offset = 7'h00;
  logic [7:0]    w_value = 8'h00, indirect_wdata = 8'h00, ef = 8'h18, a, b;
  logic [15:0]   indirect_pointer = 16'h0000;
  logic [7:0]    cpu_condition_flags, read_data, indirect_rdata, alu_result;
  logic [4:0]    bank_select_reg, h;
  logic [8:0]    s;
  int            n_fail = 0, check_count = 0, cyc = 0, due = 0, seed = 32'hCA2ED9D3;
  csfbdm_note_t  q[$], n;
  csfbdm_core #(.RAM_BANKS(32)) DUT (.mclk, .resetn, .other_reset, .other_reset_to, .other_reset_pd,
    .instr_valid, .instr_op, .instr_offset, .instr_dest_f, .w_value, .core_event, .indirect_pointer,
    .indirect_write, .indirect_read, .indirect_wdata, .cpu_condition_flags, .bank_select_reg, .read_data,
    .indirect_rdata, .alu_result);
  task automatic end_of_test();
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic note(input int sel, input logic [7:0] v);
    q.push_back('{due, sel, v});
  endtask
  // one request per edge; results land one cycle after it is taken
  task automatic drv(input csfbdm_op_t op, input logic [6:0] off, input logic d, input logic [7:0] w,
      input csfbdm_event_t e = CSFBDM_EV_NONE, input logic [15:0] p = 16'h0000, input logic [1:0] ind = 2'h0,
      input logic [2:0] rs = 3'h0);
    @(posedge mclk);
    instr_valid <= op != CSFBDM_OP_NONE;
    instr_op <= op;
    instr_offset <= off;
    instr_dest_f <= d;
    w_value <= w;
    indirect_wdata <= w;
    core_event <= e;
    indirect_pointer <= p;
    {indirect_write, indirect_read} <= ind;
    {other_reset, other_reset_to, other_reset_pd} <= rs;
    due = cyc + 2;
  endtask
  always #5 mclk = ~mclk;
  // cycle count, which also cuts a hung run short
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 1000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  // every due note is compared, oldest first, on the falling edge once its cycle has come
  always @(negedge mclk)
    while (q.size() > 0 && q[0].due == cyc)
    begin
      n = q.pop_front();
      check(n.sel == 0 ? cpu_condition_flags : n.sel == 1 ? {3'h0, bank_select_reg} : n.sel == 2 ? read_data :
            n.sel == 3 ? indirect_rdata : alu_result, n.val);
    end
  initial
  begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    drv(CSFBDM_OP_NONE, 7'h00, 1'b0, 8'h00);
    note(0, 8'h18);
    note(1, 8'h00);
    // add and subtract, stored operand read back the very next cycle; first ones hit carry boundaries
    for (int i = 0; i < 12; i++)
    begin
      a = i == 0 ? 8'h80 : i == 1 ? 8'h10 : 8'($random(seed));
      b = i == 0 ? 8'h80 : i == 1 ? 8'h01 : 8'($random(seed));
      drv(CSFBDM_OP_MOVE, 7'h20 + 7'(i), 1'b1, a);
      drv(i[0] ? CSFBDM_OP_SUB : CSFBDM_OP_ADD, 7'h20 + 7'(i), 1'b0, b);
      if (i[0])
        b = ~b;
      s = {1'b0, a} + {1'b0, b} + 9'(i[0]);
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(i[0]);
      ef[2:0] = {s[7:0] == 8'h00, h[4], s[8]};
      note(2, a);
      note(4, s[7:0]);
      note(0, ef);
    end
    // rotates through carry at the last general ram place
    for (int j = 0; j < 4; j++)
    begin
      a = j[0] ? 8'h80 : 8'h01;
      drv(CSFBDM_OP_MOVE, 7'h6F, 1'b1, a);
      drv(j[1] ? CSFBDM_OP_ROT_RIGHT : CSFBDM_OP_ROT_LEFT, 7'h6F, 1'b0, 8'h00);
      note(4, j[1] ? {ef[0], a[7:1]} : {a[6:0], ef[0]});
      ef[0] = j[1] ? a[0] : a[7];
      note(0, ef);
    end
    // the flag register as destination: plain move, flag-setting add, clear
    drv(CSFBDM_OP_MOVE, 7'h03, 1'b1, 8'hFF);
    ef = {3'h0, ef[4:3], 3'h7};
    note(0, ef);
    drv(CSFBDM_OP_ADD, 7'h03, 1'b1, 8'hE9);
    s = {1'b0, ef} + 9'h0E9;
    h = {1'b0, ef[3:0]} + 5'h09;
    ef[2:0] = {s[7:0] == 8'h00, h[4], s[8]};
    note(0, ef);
    drv(CSFBDM_OP_CLEAR, 7'h03, 1'b1, 8'h00);
    ef[2] = 1'b1;
    note(0, ef);
    // sleep, watchdog timeout, watchdog clear, then two other resets
    for (int k = 0; k < 5; k++)
    begin
      drv(CSFBDM_OP_NONE, 7'h00, 1'b0, 8'h00, k == 0 ? CSFBDM_EV_SLEEP : k == 1 ? CSFBDM_EV_WATCHDOG_TIMEOUT :
          k == 2 ? CSFBDM_EV_WATCHDOG_CLEAR : CSFBDM_EV_NONE, 16'h0000, 2'h0, k == 3 ? 3'h5 : k == 4 ? 3'h6 : 3'h0);
      ef[4:3] = k == 0 ? 2'b10 : k == 1 ? {1'b0, ef[3]} : k == 2 ? 2'b11 : k == 3 ? 2'b01 : 2'b10;
      note(0, ef);
    end
    // bank select, common ram across banks, peripheral places read zero
    drv(CSFBDM_OP_MOVE, 7'h08, 1'b1, 8'h05);
    note(1, 8'h05);
    drv(CSFBDM_OP_MOVE, 7'h7F, 1'b1, 8'hA5);
    drv(CSFBDM_OP_MOVE, 7'h0C, 1'b1, 8'h55);
    drv(CSFBDM_OP_MOVE, 7'h08, 1'b1, 8'h01);
    drv(CSFBDM_OP_LOGIC, 7'h7F, 1'b0, 8'hFF);
    note(2, 8'hA5);
    drv(CSFBDM_OP_LOGIC, 7'h0C, 1'b0, 8'hFF);
    ef[2] = 1'b1;
    note(2, 8'h00);
    note(0, ef);
    // linear index 83 is bank 1 offset 0x23
    drv(CSFBDM_OP_NONE, 7'h00, 1'b0, 8'h3C, CSFBDM_EV_NONE, 16'h2053, 2'h2);
    drv(CSFBDM_OP_LOGIC, 7'h23, 1'b0, 8'hFF, CSFBDM_EV_NONE, 16'h00A3, 2'h1);
    ef[2] = 1'b0;
    note(2, 8'h3C);
    note(3, 8'h3C);
    drv(CSFBDM_OP_LOGIC, 7'h03, 1'b0, 8'hFF, CSFBDM_EV_NONE, 16'h000C, 2'h1);
    note(2, ef);
    note(3, 8'h00);
    drv(CSFBDM_OP_NONE, 7'h00, 1'b0, 8'h00);
    repeat (3) @(posedge mclk);
    end_of_test();
  end
endmodule
`default_nettype wire
